// File: rtl/bir_defs.vh
// Constants for the bus interrupt requester
`ifndef BIR_DEFS_VH
`define BIR_DEFS_VH
`define BIR_CR_LVL_LSB 0
`define BIR_CR_LVL_MSB 2
`define BIR_CR_XVEC 3
`define BIR_CR_ENA 4
`define BIR_CR_ACLR 5
`define BIR_CR_FACLR 6
`define BIR_CR_FLAG 7
`define BIR_CR_RESET 8'h00
`define BIR_VR_RESET 8'h0F
`define BIR_RST_CYCLES 2'h2
`endif

// File: rtl/bir_core.v
// Four-source bus interrupt requester with register port and acknowledge logic
//
// Function
// - Transfer acknowledge asserted only after read/vector data driven or write data captured.
// - Eight registers, all readable and writable, selected by address bits 1 to 3.
// - Read direction and address captured at chip select falling edge.
// - Write direction, address and data captured at chip select falling edge.
// - Control register n bit 4 enables request input n.
// - Enabled asserted source drives request line numbered by its level field.
// - Shared level line stays asserted until every pending source there is served.
// - Level zero never raises any request line.
// - On acknowledge fall, capture direction and level, compare with pending requests.
// - Without chain input, take no action; cycle ends at acknowledge negation.
// - Chain input with no match passes acknowledge onward on chain output.
// - Internal match drives vector byte, then transfer acknowledge; chain output negated.
// - External match asserts external strobe and two-bit source code; chain negated.
// - Highest-numbered matching source is served first.
// - Internal answers also assert strobe and valid source code.
// - Internal answer releases data and acknowledge only after acknowledge negation.
// - Auto-clear bit clears the served source's enable during acknowledge.
// - New device requests are ignored while acknowledge is asserted.
// - Chip select with acknowledge low two clocks resets all registers.
// - Flag bit 7 cleared on acknowledge when its self-clear bit is set.
`include "bir_defs.vh"
`timescale 1ns/1ps
`default_nettype none
module bir_core (
  input wire mclk,
  input wire rst,
  input wire cs_n,
  input wire rw,
  input wire [2:0] addr,
  input wire [7:0] data_in,
  input wire iack_n,
  input wire iackin_n,
  input wire [3:0] device_request_inputs,
  output reg [7:0] data_out,
  output reg data_oe,
  output reg dtack_oe,
  output reg [7:1] irq_oe,
  output reg iackout_n,
  output reg ack_external_strobe,
  output reg ack_source_code_lsb,
  output reg ack_source_code_msb
);
  localparam [4:0] ST_IDLE = 5'h01;
  localparam [4:0] ST_ACC = 5'h02;
  localparam [4:0] ST_DONE = 5'h04;
  localparam [4:0] ST_IACK = 5'h08;
  localparam [4:0] ST_HOLD = 5'h10;

  // First stage of each synchroniser; nothing but the second stage reads these
  reg cs_s1_q;
  reg ia_s1_q;
  reg ch_s1_q;
  reg [3:0] req_s1_q;
  // Second stage, the only copy the control logic may look at
  reg cs_n_q;
  reg iack_n_q;
  reg iackin_n_q;
  // Previous second-stage values for edge detection
  reg cs_prev_q;
  reg iack_prev_q;
  reg [3:0] req_q;
  reg [3:0] req_lat_q;
  reg [4:0] st_q;
  reg lat_rw_q;
  reg [2:0] lat_addr_q;
  reg [7:0] lat_data_q;
  reg [1:0] rst_cnt_q;
  reg [1:0] src_q;
  reg ext_q;
  reg [3:0] match;
  reg [1:0] win;
  reg any;
  reg [7:1] irq_d;
  reg [7:0] rd_byte;
  integer k;
  wire chip_rst;
  wire cs_fall;
  wire iack_fall;
  wire acc_wr;
  wire serve;
  // Per-source registers flattened so each source owns its own byte slice
  wire [31:0] ctl_w;
  wire [31:0] vec_w;
  genvar g;

  // Two flops per async input; only the second is used
  always @(posedge mclk) begin
    cs_s1_q <= cs_n;
    ia_s1_q <= iack_n;
    ch_s1_q <= iackin_n;
    req_s1_q <= device_request_inputs;
    cs_n_q <= cs_s1_q;
    iack_n_q <= ia_s1_q;
    iackin_n_q <= ch_s1_q;
    req_q <= req_s1_q;
    cs_prev_q <= cs_n_q;
    iack_prev_q <= iack_n_q;
  end

  assign cs_fall = cs_prev_q & ~cs_n_q;
  assign iack_fall = iack_prev_q & ~iack_n_q;
  assign chip_rst = (rst_cnt_q == `BIR_RST_CYCLES);
  // Register write lands in the cycle after capture
  assign acc_wr = (st_q == ST_ACC) & ~lat_rw_q;
  // A source is served when the chain reaches us with a match
  assign serve = (st_q == ST_IACK) & ~iack_n_q & ~iackin_n_q & any;

  // Requests frozen during acknowledge so the chain decision is stable
  always @(posedge mclk) begin
    if (rst) begin
      req_lat_q <= 4'h0;
    end else if (iack_n_q) begin
      req_lat_q <= req_q;
    end
  end

  // Count clocks of chip select and acknowledge both low
  always @(posedge mclk) begin
    if (rst) begin
      rst_cnt_q <= 2'h0;
    end else if (!cs_n_q && !iack_n_q) begin
      if (!chip_rst) begin
        rst_cnt_q <= rst_cnt_q + 2'h1;
      end
    end else begin
      rst_cnt_q <= 2'h0;
    end
  end

  // Match on level; level zero never matches; highest index wins
  always @* begin
    match = 4'h0;
    win = 2'h0;
    for (k = 0; k < 4; k = k + 1) begin
      match[k] = req_lat_q[k] & ctl_w[8 * k + `BIR_CR_ENA] &
        (ctl_w[8 * k + `BIR_CR_LVL_LSB +: 3] == lat_addr_q) & (lat_addr_q != 3'h0);
      if (match[k]) begin
        win = k[1:0];
      end
    end
    any = |match;
  end

  // Request lines: OR of every enabled active source at its level
  always @* begin
    irq_d = 7'h00;
    for (k = 0; k < 4; k = k + 1) begin
      if (req_lat_q[k] && ctl_w[8 * k + `BIR_CR_ENA] && ctl_w[8 * k + `BIR_CR_LVL_LSB +: 3] != 3'h0) begin
        irq_d[ctl_w[8 * k + `BIR_CR_LVL_LSB +: 3]] = 1'b1;
      end
    end
  end

  always @* begin
    rd_byte = lat_addr_q[2] ? vec_w[8 * lat_addr_q[1:0] +: 8] : ctl_w[8 * lat_addr_q[1:0] +: 8];
  end

  // One control and one vector register per source
  generate
    for (g = 0; g < 4; g = g + 1) begin : g_src
      localparam [1:0] IDX = g;
      reg [7:0] ctl_r;
      reg [7:0] vec_r;
      wire won;
      assign won = serve & (win == IDX);
      always @(posedge mclk) begin
        if (rst || chip_rst) begin
          ctl_r <= `BIR_CR_RESET;
          vec_r <= `BIR_VR_RESET;
        end else if (acc_wr && lat_addr_q[1:0] == IDX) begin
          if (lat_addr_q[2]) begin
            vec_r <= lat_data_q;
          end else begin
            ctl_r <= lat_data_q;
          end
        end else if (won) begin
          // No write can coincide: accesses are refused during acknowledge
          if (ctl_r[`BIR_CR_ACLR]) begin
            ctl_r[`BIR_CR_ENA] <= 1'b0;
          end
          if (ctl_r[`BIR_CR_FACLR]) begin
            ctl_r[`BIR_CR_FLAG] <= 1'b0;
          end
        end
      end
      assign ctl_w[8 * g +: 8] = ctl_r;
      assign vec_w[8 * g +: 8] = vec_r;
    end
  endgenerate

  always @(posedge mclk) begin
    if (rst || chip_rst) begin
      st_q <= ST_IDLE;
      lat_rw_q <= 1'b1;
      lat_addr_q <= 3'h0;
      lat_data_q <= 8'h00;
      src_q <= 2'h0;
      ext_q <= 1'b0;
      data_out <= 8'h00;
      data_oe <= 1'b0;
      dtack_oe <= 1'b0;
      irq_oe <= 7'h00;
      iackout_n <= 1'b1;
      ack_external_strobe <= 1'b1;
      ack_source_code_lsb <= 1'b0;
      ack_source_code_msb <= 1'b0;
    end else begin
      irq_oe <= irq_d;
      case (st_q)
        ST_IDLE: begin
          if (iack_fall) begin
            lat_rw_q <= rw;
            lat_addr_q <= addr;
            st_q <= ST_IACK;
          end else if (cs_fall) begin
            // Inputs held stable around the edge, so the synchronised edge sees them
            lat_rw_q <= rw;
            lat_addr_q <= addr;
            lat_data_q <= data_in;
            st_q <= ST_ACC;
          end
        end
        ST_ACC: begin
          // Writes are stored by the per-source registers in this state
          if (lat_rw_q) begin
            data_out <= rd_byte;
            data_oe <= 1'b1;
          end
          st_q <= ST_DONE;
        end
        ST_DONE: begin
          // Acknowledge follows data by a clock
          dtack_oe <= 1'b1;
          if (cs_n_q) begin
            dtack_oe <= 1'b0;
            data_oe <= 1'b0;
            st_q <= ST_IDLE;
          end
        end
        ST_IACK: begin
          if (iack_n_q) begin
            st_q <= ST_IDLE;
          end else if (!iackin_n_q) begin
            if (!any) begin
              iackout_n <= 1'b0;
            end else begin
              src_q <= win;
              ext_q <= ctl_w[8 * win + `BIR_CR_XVEC];
              ack_external_strobe <= 1'b0;
              ack_source_code_lsb <= win[0];
              ack_source_code_msb <= win[1];
              if (!ctl_w[8 * win + `BIR_CR_XVEC]) begin
                data_out <= vec_w[8 * win +: 8];
                data_oe <= 1'b1;
              end
            end
            st_q <= ST_HOLD;
          end
        end
        ST_HOLD: begin
          // External answers leave vector and acknowledge to the peripheral
          if (!ext_q && !iackout_n) begin
            dtack_oe <= 1'b0;
          end else if (!ext_q && data_oe) begin
            dtack_oe <= 1'b1;
          end
          if (iack_n_q) begin
            dtack_oe <= 1'b0;
            data_oe <= 1'b0;
            iackout_n <= 1'b1;
            ack_external_strobe <= 1'b1;
            st_q <= ST_IDLE;
          end
        end
        default: begin
          st_q <= ST_IDLE;
        end
      endcase
    end
  end
endmodule // bir_core
`default_nettype wire

// File: testbench/bir_core_properties.sv
// Port assertions for the bus interrupt requester
`timescale 1ns/1ps
`default_nettype none
module bir_core_properties (
  input wire logic mclk, rst, cs_n, rw, iack_n, iackin_n, data_oe, dtack_oe, iackout_n, ack_external_strobe,
  input wire logic [7:1] irq_oe
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  sequence s_access; $fell(cs_n) && iack_n; endsequence
  sequence s_released; $past(cs_n) && $past(iack_n); endsequence
  a_access_ack_time: assert property (s_access |-> !dtack_oe [*3] ##[1:5] dtack_oe)
    else $error("ack out of time");
  a_data_before_ack: assert property ($rose(dtack_oe) && rw |-> $past(data_oe))
    else $error("ack before data");
  a_answer_held: assert property ($fell(data_oe) || $fell(dtack_oe) |-> s_released)
    else $error("answer dropped early");
  a_pass_quiet: assert property (!iackout_n |-> !data_oe && !dtack_oe && ack_external_strobe)
    else $error("pass while answering");
  a_no_chain_idle: assert property (iackin_n [*5] |-> iackout_n)
    else $error("pass without chain");
  a_strobe_cause: assert property ($fell(ack_external_strobe) |-> !iack_n && !iackin_n)
    else $error("strobe outside ack");
  a_internal_strobe: assert property (data_oe && !iack_n |-> !ack_external_strobe)
    else $error("vector without strobe");
  a_requests_frozen: assert property (!iack_n [*6] |-> (irq_oe & ~$past(irq_oe)) == 7'h00)
    else $error("request rose in ack");
endmodule // bir_core_properties
bind bir_core bir_core_properties u_props (.mclk, .rst, .cs_n, .rw, .iack_n, .iackin_n, .data_oe, .dtack_oe,
  .iackout_n, .ack_external_strobe, .irq_oe);
`default_nettype wire

// File: testbench/bir_host.sv
// Bus master and interrupt handler model
`timescale 1ns/1ps
`default_nettype none
module bir_host (
  input wire logic mclk, dtack_oe,
  input wire logic [7:0] data_out,
  output logic cs_n, rw, iack_n, iackin_n,
  output logic [2:0] addr,
  output logic [7:0] data_in
);
  logic [7:0] q;
  logic tmo;
  int n;
  initial {cs_n, rw, iack_n, iackin_n, tmo, addr, data_in} = 16'hF000;
  // Bounded so that a silent design cannot hang the run
  task wait_ack(input logic v);
    for (n = 0; dtack_oe !== v && n < 20; n++) @(posedge mclk);
    if (n == 20) tmo = 1'b1;
  endtask
  task acc(input logic r, input logic [2:0] a, input logic [7:0] d);
    @(posedge mclk);
    cs_n <= 1'b0; // Held with rw, addr and data until acknowledged
    {rw, addr, data_in} <= {r, a, d};
    wait_ack(1'b1);
    q = data_out;
    cs_n <= 1'b1;
    data_in <= ~d; // A released bus does not keep its last byte
    wait_ack(1'b0);
  endtask
  task ack_go(input logic [2:0] lvl, input logic chain);
    @(posedge mclk);
    {iack_n, rw, addr, iackin_n} <= {2'b01, lvl, ~chain}; // Level held for the whole cycle
    repeat (8) @(posedge mclk);
  endtask
  task ack_end;
    @(posedge mclk);
    {iack_n, iackin_n} <= 2'b11;
    repeat (6) @(posedge mclk);
  endtask
  task chip_reset;
    @(posedge mclk);
    {cs_n, iack_n} <= 2'b00; // Held well past two synchronised clocks
    repeat (8) @(posedge mclk);
    cs_n <= 1'b1;
    ack_end();
  endtask
endmodule // bir_host
`default_nettype wire

// File: testbench/tb_bir_core.sv
// Self-checking bench for the bus interrupt requester
`timescale 1ns/1ps
`default_nettype none
module tb_bir_core;
  logic mclk, rst, data_oe, dtack_oe, iackout_n, ext_stb, code_lo, code_hi;
  logic [3:0] req;
  logic [7:0] data_out, ctl[4], vec[4];
  logic [7:0] cfg[4] = '{8'h1A, 8'hD5, 8'h10, 8'h35};
  logic [7:1] irq_oe;
  logic [31:0] seed;
  wire logic cs_n, rw, iack_n, iackin_n;
  wire logic [2:0] addr;
  wire logic [7:0] data_in;
  int fail_count, checks;
  bir_host p (.mclk, .dtack_oe, .data_out, .cs_n, .rw, .iack_n, .iackin_n, .addr, .data_in);
  bir_core dut (.mclk, .rst, .cs_n, .rw, .addr, .data_in, .iack_n, .iackin_n, .device_request_inputs(req),
    .data_out, .data_oe, .dtack_oe, .irq_oe, .iackout_n, .ack_external_strobe(ext_stb),
    .ack_source_code_lsb(code_lo), .ack_source_code_msb(code_hi));
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [7:0] exp_irq();
    logic [7:0] e;
    e = 8'h00;
    for (int i = 0; i < 4; i++) if (ctl[i][4] && req[i] && ctl[i][2:0] != 3'h0) e[ctl[i][2:0]] = 1'b1;
    return e;
  endfunction
  task chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task final_report;
    if (p.tmo) fail_count++;
    $display("fail_count %0d checks %0d", fail_count, checks);
    if (fail_count == 0 && checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task acc(input logic r, input logic [2:0] a, input logic [7:0] d);
    p.acc(r, a, d);
    if (p.tmo) final_report();
    if (!r && !a[2]) ctl[a[1:0]] = d;
    if (!r && a[2]) vec[a[1:0]] = d;
  endtask
  task rd(input logic [2:0] a);
    acc(1'b1, a, 8'h00);
    chk(p.q, a[2] ? vec[a[1:0]] : ctl[a[1:0]]);
  endtask
  // Flags are {dtack_oe, data_oe, strobe, chain out}; a low strobe marks a matched source
  task ack(input logic [2:0] l, input logic ch, input logic [3:0] fl, input logic [1:0] s);
    p.ack_go(l, ch);
    #1;
    chk({4'h0, dtack_oe, data_oe, ext_stb, iackout_n}, {4'h0, fl});
    if (!fl[1]) chk({6'h00, code_hi, code_lo}, {6'h00, s});
    if (fl[2]) chk(data_out, vec[s]);
    if (!fl[1] && ctl[s][5]) ctl[s][4] = 1'b0;
    if (!fl[1] && ctl[s][6]) ctl[s][7] = 1'b0;
    p.ack_end();
  endtask
  initial begin
    rst = 1'b1;
    req = 4'h0;
    seed = 32'h21824A65;
    repeat (12) @(posedge mclk);
    rst <= 1'b0;
    repeat (3) @(posedge mclk);
    p.chip_reset();
    for (int i = 0; i < 4; i++) {ctl[i], vec[i]} = 16'h000F;
    for (int a = 0; a < 8; a++) rd(3'(a));
    for (int a = 0; a < 16; a++) begin
      seed = lfsr(seed);
      acc(1'b0, seed[10:8], seed[7:0]);
      rd(seed[10:8]);
    end
    for (int i = 0; i < 4; i++) acc(1'b0, 3'(i), cfg[i]);
    req <= 4'hF;
    repeat (6) @(posedge mclk);
    chk({irq_oe, 1'b0}, exp_irq());
    ack(3'h5, 1'b1, 4'hD, 2'h3);
    rd(3'h3);
    chk({irq_oe, 1'b0}, exp_irq());
    ack(3'h5, 1'b1, 4'hD, 2'h1);
    rd(3'h1);
    ack(3'h2, 1'b1, 4'h1, 2'h0);
    ack(3'h6, 1'b1, 4'h2, 2'h0);
    ack(3'h5, 1'b0, 4'h3, 2'h0);
    req <= 4'h0;
    repeat (6) @(posedge mclk);
    chk({irq_oe, 1'b0}, exp_irq());
    final_report();
  end
endmodule // tb_bir_core
`default_nettype wire
